// >>> design/pso_sync_preset.sv
// synchronization trigger, output mask and channel preset logic of the timer
//
// Function
// - a rising edge on trigger 0 is a sync trigger only while bit 4 is set.
// - with bit 3 clear the active mask copies its buffer every clock.
// - with bit 3 set the active mask loads from its buffer only on a sync.
// - with bit 2 set a detected trigger reloads the counter with its start.
// - the reload setting applies only while sync_mode_select is zero.
// - with bit 1 set the counter reaching its modulo is a loading point.
// - with bit 0 set the counter reaching its start is a loading point.
// - bits 7..0 of the preset register hold one preset level per channel.
// - a preset level of 1 drives an unmasked output high, 0 drives it low.
// - bits 31..8 of the preset register read as zero.
// - writing 1 to the preset strobe forces presets, it always reads 0.
// - writing 1 to soft_sync_trigger raises a software sync trigger.
// - rising edges on triggers 1 and 2 count when bits 5 and 6 are set.
// - a sync moves buffered modulo, compares and mask into active use.
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module pso_sync_preset (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire pso_pkg::pso_bus_req_t busReq,
    output logic [31:0] rdData_q,
    // hardware trigger pins
    input wire logic [pso_pkg::NUM_HWTRIG-1:0] hwTrigIn,
    // channel outputs and sync pulse
    output logic [pso_pkg::NUM_CH-1:0] chanOut_q,
    output logic syncPulse_q
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic cmpHit(input logic [7:0] a);
        cmpHit = (a >= pso_pkg::OFS_CMP_BASE) && (a[1:0] == 2'h0) &&
            (a < pso_pkg::OFS_CMP_BASE + 8'(4 * pso_pkg::NUM_CH));
    endfunction

    function automatic logic [2:0] cmpIdx(input logic [7:0] a);
        logic [7:0] d;
        d = a - pso_pkg::OFS_CMP_BASE;
        cmpIdx = d[4:2];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] syncCfg_q;
    logic [7:0] preset_q;
    logic [7:0] maskBuf_q;
    logic [7:0] maskAct_q;
    logic [15:0] modBuf_q;
    logic [15:0] modAct_q;
    logic [15:0] initVal_q;
    logic sync_mode_select_q;
    logic run_q;
    logic [15:0] count_q;
    logic softPend_q;
    logic pend_q;
    logic [15:0] cmpBuf_q [pso_pkg::NUM_CH];
    logic [15:0] cmpAct_q [pso_pkg::NUM_CH];
    logic [pso_pkg::NUM_CH-1:0] chanState_q;
    logic [pso_pkg::NUM_HWTRIG-1:0] hwEdge;
    logic [pso_pkg::NUM_HWTRIG-1:0] hwEn;
    logic wrSync, wrCtrl, presetPulse, softHit, trigAny;
    logic atMax, atMin, pointHit, anyPoint, syncEvent, reloadNow;

    assign wrSync = busReq.wr && (busReq.addr == pso_pkg::OFS_SYNC);
    assign wrCtrl = busReq.wr && (busReq.addr == pso_pkg::OFS_CTRL);
    assign presetPulse = wrCtrl &&
        busReq.wdata[pso_pkg::CTRL_PRESET_BIT];
    assign softHit = wrSync && busReq.wdata[pso_pkg::SYNC_SOFT_BIT];
    assign hwEn = syncCfg_q[pso_pkg::SYNC_HWT0_BIT +: pso_pkg::NUM_HWTRIG];

    ////////////////////////////////////////////////////////////////////////
    // three-flop synchronisers, a change counts once stages 2 and 3 agree
    genvar g;
    generate
        for (g = 0; g < pso_pkg::NUM_HWTRIG; g++) begin : gTrig
            logic s1_q, s2_q, s3_q, lvl_q;
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    lvl_q <= 1'b0;
                end else begin
                    s1_q <= hwTrigIn[g];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        lvl_q <= s3_q;
                    end
                end
            end
            // edge against the previous filtered level
            assign hwEdge[g] = (s2_q == s3_q) && s3_q && !lvl_q;
        end
    endgenerate

    // any enabled source starts a sync
    assign trigAny = softHit || |(hwEdge & hwEn);

    assign atMax = syncCfg_q[pso_pkg::SYNC_MAX_BIT] &&
        (count_q == modAct_q);
    assign atMin = syncCfg_q[pso_pkg::SYNC_MIN_BIT] &&
        (count_q == initVal_q);
    assign anyPoint = syncCfg_q[pso_pkg::SYNC_MAX_BIT] ||
        syncCfg_q[pso_pkg::SYNC_MIN_BIT];
    assign pointHit = run_q && (atMax || atMin);
    // without a loading point the transfer follows the trigger directly
    assign syncEvent = (pend_q || trigAny) && (pointHit || !anyPoint);
    assign reloadNow = trigAny && !sync_mode_select_q &&
        syncCfg_q[pso_pkg::SYNC_RELOAD_BIT];

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            syncCfg_q <= pso_pkg::SYNC_RST;
            preset_q <= pso_pkg::PRESET_RST;
            maskBuf_q <= pso_pkg::MASK_RST;
            modBuf_q <= pso_pkg::MODULO_RST;
            initVal_q <= pso_pkg::INITVAL_RST;
            sync_mode_select_q <= 1'b0;
            run_q <= 1'b0;
        end else if (busReq.wr) begin
            if (busReq.addr == pso_pkg::OFS_SYNC) begin
                syncCfg_q <= {1'b0, busReq.wdata[6:0]};
            end else if (busReq.addr == pso_pkg::OFS_PRESET) begin
                preset_q <= busReq.wdata[7:0];
            end else if (busReq.addr == pso_pkg::OFS_MASK) begin
                maskBuf_q <= busReq.wdata[7:0];
            end else if (busReq.addr == pso_pkg::OFS_MODULO) begin
                modBuf_q <= busReq.wdata[15:0];
            end else if (busReq.addr == pso_pkg::OFS_INITVAL) begin
                initVal_q <= busReq.wdata[15:0];
            end else if (busReq.addr == pso_pkg::OFS_CTRL) begin
                sync_mode_select_q <= busReq.wdata[pso_pkg::CTRL_MODE_BIT];
                run_q <= busReq.wdata[pso_pkg::CTRL_RUN_BIT];
            end
        end
    end

    // soft trigger reads back as pending until the sync consumes it;
    // one consumed in its own write cycle must not stick as pending
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            softPend_q <= 1'b0;
            pend_q <= 1'b0;
        end else begin
            if (softHit && !syncEvent) begin
                softPend_q <= 1'b1;
            end else if (syncEvent) begin
                softPend_q <= 1'b0;
            end
            if (trigAny && !syncEvent) begin
                pend_q <= 1'b1;
            end else if (syncEvent) begin
                pend_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            modAct_q <= pso_pkg::MODULO_RST;
        end else if (syncEvent) begin
            modAct_q <= modBuf_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            maskAct_q <= pso_pkg::MASK_RST;
        end else if (!syncCfg_q[pso_pkg::SYNC_MASKSEL_BIT]) begin
            maskAct_q <= maskBuf_q;
        end else if (syncEvent) begin
            maskAct_q <= maskBuf_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count_q <= pso_pkg::INITVAL_RST;
        end else if (reloadNow) begin
            count_q <= initVal_q;
        end else if (run_q) begin
            if (count_q == modAct_q) begin
                count_q <= initVal_q;
            end else begin
                count_q <= count_q + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    generate
        for (g = 0; g < pso_pkg::NUM_CH; g++) begin : gChan
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    cmpBuf_q[g] <= pso_pkg::CMP_RST;
                    cmpAct_q[g] <= pso_pkg::CMP_RST;
                end else begin
                    if (busReq.wr && cmpHit(busReq.addr) &&
                        cmpIdx(busReq.addr) == 3'(g)) begin
                        cmpBuf_q[g] <= busReq.wdata[15:0];
                    end
                    if (syncEvent) begin
                        cmpAct_q[g] <= cmpBuf_q[g];
                    end
                end
            end
            // edge aligned: high from the start value up to the compare
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    chanState_q[g] <= 1'b0;
                end else if (presetPulse) begin
                    chanState_q[g] <= preset_q[g];
                end else if (run_q && count_q == cmpAct_q[g]) begin
                    chanState_q[g] <= 1'b0;
                end else if (run_q && count_q == initVal_q) begin
                    chanState_q[g] <= 1'b1;
                end
            end
        end
    endgenerate

    // masked channels sit at their inactive low level
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            chanOut_q <= '0;
            syncPulse_q <= 1'b0;
        end else begin
            chanOut_q <= chanState_q & ~maskAct_q;
            syncPulse_q <= syncEvent;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data only in the cycle after the strobe, unmapped reads zero
    always_ff @(posedge clk_sys) begin
        if (rst || !busReq.rd) begin
            rdData_q <= '0;
        end else if (busReq.addr == pso_pkg::OFS_SYNC) begin
            rdData_q <= {24'h000000, softPend_q, syncCfg_q[6:0]};
        end else if (busReq.addr == pso_pkg::OFS_PRESET) begin
            rdData_q <= {24'h000000, preset_q};
        end else if (busReq.addr == pso_pkg::OFS_MASK) begin
            rdData_q <= {24'h000000, maskBuf_q};
        end else if (busReq.addr == pso_pkg::OFS_MODULO) begin
            rdData_q <= {16'h0000, modBuf_q};
        end else if (busReq.addr == pso_pkg::OFS_INITVAL) begin
            rdData_q <= {16'h0000, initVal_q};
        end else if (busReq.addr == pso_pkg::OFS_CTRL) begin
            rdData_q <= {29'h0, run_q, sync_mode_select_q, 1'b0};
        end else if (busReq.addr == pso_pkg::OFS_COUNT) begin
            rdData_q <= {16'h0000, count_q};
        end else if (cmpHit(busReq.addr)) begin
            rdData_q <= {16'h0000, cmpBuf_q[cmpIdx(busReq.addr)]};
        end else begin
            rdData_q <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence sPresetWrite;
        presetPulse && run_q == 1'b0;
    endsequence
    sequence sPresetSeen;
        ##1 chanState_q == $past(preset_q) ##1
            chanOut_q == ($past(preset_q, 2) & ~$past(maskAct_q));
    endsequence

    a_hw_trigger_zero_enable_enabled: assert property (
        hwEn[0] && hwEdge[0] |-> trigAny ##1 (pend_q || $past(syncEvent)))
        else $error("enabled trigger 0 edge did not start a sync");
    a_trig_source: assert property (
        trigAny |-> softHit || (hwEdge & hwEn) != '0)
        else $error("sync trigger without an enabled source");
    a_mask_follow: assert property (
        !syncCfg_q[pso_pkg::SYNC_MASKSEL_BIT] |=>
            maskAct_q == $past(maskBuf_q))
        else $error("active mask did not follow its buffer");
    a_mask_hold: assert property (
        syncCfg_q[pso_pkg::SYNC_MASKSEL_BIT] && !syncEvent |=>
            $stable(maskAct_q))
        else $error("active mask changed without a sync");
    a_counter_reload: assert property (
        trigAny && !sync_mode_select_q && syncCfg_q[pso_pkg::SYNC_RELOAD_BIT]
            |=> count_q == $past(initVal_q))
        else $error("counter not reloaded on trigger");
    a_max_point: assert property (
        pend_q && run_q && syncCfg_q[pso_pkg::SYNC_MAX_BIT] &&
            count_q == modAct_q |=> modAct_q == $past(modBuf_q) && !pend_q)
        else $error("maximum loading point missed");
    a_min_point: assert property (
        pend_q && run_q && syncCfg_q[pso_pkg::SYNC_MIN_BIT] &&
            count_q == initVal_q |-> syncEvent ##1 syncPulse_q)
        else $error("minimum loading point missed");
    a_preset_force: assert property (
        sPresetWrite |-> sPresetSeen)
        else $error("channel outputs not forced to preset levels");
    a_reserved_zero: assert property (
        busReq.rd && busReq.addr == pso_pkg::OFS_PRESET |=>
            rdData_q[31:8] == 24'h000000 && rdData_q[7:0] == $past(preset_q))
        else $error("preset read back wrong");
    a_strobe_reads0: assert property (
        busReq.rd && busReq.addr == pso_pkg::OFS_CTRL |=> !rdData_q[0])
        else $error("preset strobe read back as one");
    a_soft_trigger: assert property (
        softHit |-> trigAny ##1 (softPend_q || $past(syncEvent)))
        else $error("software trigger lost");
    a_sync_transfer: assert property (
        syncEvent |=> modAct_q == $past(modBuf_q) &&
            cmpAct_q[0] == $past(cmpBuf_q[0]))
        else $error("buffered values not transferred on sync");

endmodule

`default_nettype wire

// >>> shared/pso_pkg.sv
// register map, field positions and carrier types of the sync/preset block
package pso_pkg;
    localparam int NUM_CH = 8;
    localparam int CNT_W = 16;
    localparam int NUM_HWTRIG = 3;
    // register byte offsets
    localparam logic [7:0] OFS_SYNC = 8'h00;
    localparam logic [7:0] OFS_PRESET = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_MODULO = 8'h0c;
    localparam logic [7:0] OFS_INITVAL = 8'h10;
    localparam logic [7:0] OFS_CTRL = 8'h14;
    localparam logic [7:0] OFS_COUNT = 8'h18;
    localparam logic [7:0] OFS_CMP_BASE = 8'h20;
    // sync_trigger_config fields
    localparam int SYNC_MIN_BIT = 0;
    localparam int SYNC_MAX_BIT = 1;
    localparam int SYNC_RELOAD_BIT = 2;
    localparam int SYNC_MASKSEL_BIT = 3;
    localparam int SYNC_HWT0_BIT = 4;
    localparam int SYNC_SOFT_BIT = 7;
    // control register fields
    localparam int CTRL_PRESET_BIT = 0;
    localparam int CTRL_MODE_BIT = 1;
    localparam int CTRL_RUN_BIT = 2;
    // reset values
    localparam logic [7:0] SYNC_RST = 8'h00;
    localparam logic [7:0] PRESET_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [15:0] MODULO_RST = 16'hffff;
    localparam logic [15:0] INITVAL_RST = 16'h0000;
    localparam logic [15:0] CMP_RST = 16'h0000;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } pso_bus_req_t;
endpackage

// >>> verification/pso_trig_src.sv
// hardware trigger source model driving the three trigger pins
`timescale 1ns/1ps
`default_nettype none

module pso_trig_src (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // fire requests from the bench, one bit per pin
    input wire logic [2:0] fireReq,
    // trigger pins
    output logic [2:0] hwTrig
);
    int hold [3];

    // level held four cycles: a pin that stays high must not retrigger
    always @(posedge clk_sys) begin
        for (int i = 0; i < 3; i++) begin
            if (rst) begin
                hold[i] <= 0;
            end else if (fireReq[i]) begin
                hold[i] <= 4;
            end else if (hold[i] > 0) begin
                hold[i] <= hold[i] - 1;
            end
        end
    end

    always @* begin
        for (int i = 0; i < 3; i++) begin
            hwTrig[i] = (hold[i] > 0);
        end
    end
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// self-checking bench for the sync trigger and channel preset block
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clk_sys;
    logic rst;
    pso_pkg::pso_bus_req_t busReq;
    logic [31:0] rdData_q;
    logic [2:0] hwTrigIn;
    logic [2:0] fireReq;
    logic [7:0] chanOut_q;
    logic syncPulse_q;
    int fails = 0;
    int checks_done = 0;
    int pulses = 0;
    int seed;
    int p0;
    logic [31:0] v;
    logic [7:0] expPre;
    logic [7:0] expMask;

    pso_sync_preset dut (.clk_sys(clk_sys), .rst(rst), .busReq(busReq),
        .rdData_q(rdData_q), .hwTrigIn(hwTrigIn), .chanOut_q(chanOut_q),
        .syncPulse_q(syncPulse_q));
    pso_trig_src src (.clk_sys(clk_sys), .rst(rst), .fireReq(fireReq),
        .hwTrig(hwTrigIn));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (syncPulse_q === 1'b1) pulses <= pulses + 1;
    end

    task automatic finish_test;
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        busReq.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        busReq.rd <= 1'b0;
        #1 d = rdData_q;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic fire(input int i);
        @(posedge clk_sys);
        fireReq <= 3'(1 << i);
        @(posedge clk_sys);
        fireReq <= 3'h0;
    endtask

    task automatic chk_reg(input logic [31:0] a, input logic [31:0] e);
        checks_done++;
        if (a !== e) begin
            fails++;
            $display("unexpected at %0t: reg %h want %h", $time, a, e);
        end
    endtask

    task automatic chk_out(input logic [7:0] a, input logic [7:0] e);
        checks_done++;
        if (a !== e) begin
            fails++;
            $display("unexpected at %0t: out %h want %h", $time, a, e);
        end
    endtask

    task automatic chk_cnt(input int a, input int e);
        checks_done++;
        if (a != e) begin
            fails++;
            $display("unexpected at %0t: pulses %0d want %0d", $time, a, e);
        end
    endtask

    task automatic chk_rng(input logic [15:0] a, input logic [15:0] lo,
        input logic [15:0] hi);
        checks_done++;
        if ((a >= lo && a <= hi) !== 1'b1) begin
            fails++;
            $display("unexpected at %0t: count %h out of range", $time, a);
        end
    endtask

    // generous bound, the whole sequence needs well under 2000 cycles
    initial begin
        #100000;
        fails++;
        $display("unexpected at %0t: run did not finish", $time);
        finish_test();
    end

    initial begin
        seed = 53150;
        rst = 1'b1;
        busReq = '0;
        fireReq = 3'h0;
        expMask = 8'h00;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rd(pso_pkg::OFS_SYNC, v);
        chk_reg(v, {24'h0, pso_pkg::SYNC_RST});
        rd(pso_pkg::OFS_PRESET, v);
        chk_reg(v, {24'h0, pso_pkg::PRESET_RST});
        rd(pso_pkg::OFS_MODULO, v);
        chk_reg(v, {16'h0, pso_pkg::MODULO_RST});
        rd(8'hfc, v);
        chk_reg(v, 32'h0);
        // park start and compare values away from the stopped counter
        rd(pso_pkg::OFS_COUNT, v);
        wr(pso_pkg::OFS_INITVAL, {16'h0, v[15:0] ^ 16'h4444});
        for (int n = 0; n < 8; n++) begin
            wr(pso_pkg::OFS_CMP_BASE + 8'(4 * n), {16'h0, v[15:0] ^ 16'h5555});
        end
        wr(pso_pkg::OFS_SYNC, 32'h80);
        repeat (3) begin
            v = $random(seed);
            expPre = v[7:0];
            wr(pso_pkg::OFS_PRESET, v);
            rd(pso_pkg::OFS_PRESET, v);
            chk_reg(v, {24'h0, expPre});
            wr(pso_pkg::OFS_CTRL, 32'h1);
            rd(pso_pkg::OFS_CTRL, v);
            chk_reg(v & 32'h1, 32'h0);
            chk_out(chanOut_q, expPre);
        end
        wr(pso_pkg::OFS_PRESET, {24'h0, ~expPre});
        wr(pso_pkg::OFS_CTRL, 32'h0);
        wait_cyc(3);
        chk_out(chanOut_q, expPre);
        wr(pso_pkg::OFS_PRESET, {24'h0, expPre});
        expMask = 8'($random(seed));
        wr(pso_pkg::OFS_MASK, {24'h0, expMask});
        wait_cyc(2);
        chk_out(chanOut_q, expPre & ~expMask);
        wr(pso_pkg::OFS_SYNC, 32'h08);
        v = $random(seed);
        wr(pso_pkg::OFS_MASK, {24'h0, v[7:0]});
        wait_cyc(3);
        chk_out(chanOut_q, expPre & ~expMask);
        p0 = pulses;
        wr(pso_pkg::OFS_SYNC, 32'h88);
        expMask = v[7:0];
        wait_cyc(3);
        chk_out(chanOut_q, expPre & ~expMask);
        chk_cnt(pulses - p0, 1);
        // the consumed soft trigger no longer reads back as pending
        rd(pso_pkg::OFS_SYNC, v);
        chk_reg(v, 32'h08);
        wr(pso_pkg::OFS_SYNC, 32'h0);
        for (int i = 0; i < 3; i++) begin
            p0 = pulses;
            fire(i);
            wait_cyc(8);
            chk_cnt(pulses - p0, 0);
            wr(pso_pkg::OFS_SYNC, 32'(1 << (4 + i)));
            fire(i);
            wait_cyc(8);
            chk_cnt(pulses - p0, 1);
            fire((i + 1) % 3);
            wait_cyc(8);
            chk_cnt(pulses - p0, 1);
        end
        wr(pso_pkg::OFS_SYNC, 32'h70);
        for (int i = 0; i < 3; i++) begin
            p0 = pulses;
            fire(i);
            wait_cyc(8);
            chk_cnt(pulses - p0, 1);
        end
        // counter reload on sync, by sync mode; the trigger acts with the
        // settings already in place, so each setting is written first
        wr(pso_pkg::OFS_CTRL, 32'h4);
        wr(pso_pkg::OFS_INITVAL, 32'h10);
        wr(pso_pkg::OFS_SYNC, 32'h04);
        wr(pso_pkg::OFS_SYNC, 32'h84);
        rd(pso_pkg::OFS_COUNT, v);
        chk_rng(v[15:0], 16'h10, 16'h18);
        wr(pso_pkg::OFS_INITVAL, 32'h8000);
        wr(pso_pkg::OFS_SYNC, 32'h00);
        wr(pso_pkg::OFS_SYNC, 32'h80);
        rd(pso_pkg::OFS_COUNT, v);
        chk_rng(v[15:0], 16'h10, 16'h40);
        wr(pso_pkg::OFS_CTRL, 32'h6);
        wr(pso_pkg::OFS_SYNC, 32'h04);
        wr(pso_pkg::OFS_SYNC, 32'h84);
        rd(pso_pkg::OFS_COUNT, v);
        chk_rng(v[15:0], 16'h10, 16'h60);
        wr(pso_pkg::OFS_MODULO, 32'h8030);
        wr(pso_pkg::OFS_CTRL, 32'h4);
        wr(pso_pkg::OFS_SYNC, 32'h84);
        rd(pso_pkg::OFS_COUNT, v);
        chk_rng(v[15:0], 16'h8000, 16'h8008);
        // a pending soft trigger waits for the enabled loading point
        for (int i = 0; i < 2; i++) begin
            p0 = pulses;
            wr(pso_pkg::OFS_SYNC, 32'(1 << i));
            wr(pso_pkg::OFS_SYNC, 32'h80 | 32'(1 << i));
            for (int k = 0; k < 100 && pulses == p0; k++) @(posedge clk_sys);
            chk_cnt(pulses - p0, 1);
            rd(pso_pkg::OFS_COUNT, v);
            chk_rng(v[15:0], 16'h8000, 16'h8008);
        end
        finish_test();
    end
endmodule
`default_nettype wire
